// ### verilog/flash_arb_cfg.svh
// Constants for the flash operation-state arbiter
`ifndef FLASH_ARB_CFG_SVH
`define FLASH_ARB_CFG_SVH
`define CLK_PERIOD_NS 8
`define SUSP_LAT_NS 20000
`define SUSP_LAT_CYC (`SUSP_LAT_NS / `CLK_PERIOD_NS)
`define STATUS_RESET 8'h00
`define EXT_RESET 8'h00
`define FILL_BYTE 8'hFF
`define ST_BUSY_BIT 0
`define ST_SUSDONE_BIT 1
`define EXT_BUSY_BIT 0
`endif

// ### verilog/flash_arb_pkg.sv
// Types for the flash operation-state arbiter
package flash_arb_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CTR = 5'h02,
        ST_PE_RUN = 5'h04,
        ST_PE_SUSPENDING = 5'h08,
        ST_PE_SUSP = 5'h10
    } state_t;
    typedef enum logic [3:0] {
        K_SUSPEND = 4'h0,
        K_RESUME = 4'h1,
        K_READ = 4'h2,
        K_PROGRAM = 4'h3,
        K_ERASE_BLK = 4'h4,
        K_ERASE_CHIP = 4'h5,
        K_WRSR = 4'h6,
        K_CTR_CMD = 4'h7,
        K_CTR_STATUS = 4'h8,
        K_STATUS_READ = 4'h9
    } kind_t;
endpackage : flash_arb_pkg

// ### verilog/toggle_sync.sv
// Three-flop toggle synchroniser giving a one-cycle event pulse
`timescale 1ns/1ps
module toggle_sync (
    input wire logic clk_sys_in, // System clock
    input wire logic rst_in, // Synchronous reset, active high
    input wire logic tog_in, // Toggle from the link domain
    output logic pulse_out // One-cycle pulse per toggle
);
    logic s1_q, s2_q, s3_q, lvl_q, pulse_q;
    logic lvl_d, pulse_d;

    // Settled level changes only when second and third flops agree
    always_comb begin
        lvl_d = lvl_q;
        if (s2_q == s3_q) begin
            lvl_d = s3_q;
        end
        pulse_d = (lvl_d != lvl_q);
    end

    // Register stage
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            s1_q <= tog_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
            pulse_q <= pulse_d;
        end
    end

    assign pulse_out = pulse_q;
endmodule : toggle_sync

// ### verilog/flash_op_arbiter.sv
// Operation-state arbiter: honours, refuses or ignores host transactions
`timescale 1ns/1ps
`include "flash_arb_cfg.svh"
// Notes on behaviour
// - Suspended state entered only when the suspend-done status bit rises.
// - Counter commands accepted during running or suspended program/erase.
// - Suspend during program or block/sector erase moves to suspended state.
// - Suspend during chip erase or status write refused; state unchanged.
// - Counter readout shows busy while busy bit set, done once clear.
// - During program/erase, counter readout returns last counter command status.
// - Status read always served; busy bit reflects the operation resulting from the same transaction.
// - Status register reads all zero after reset.
// - Array fill byte reads all ones as delivered.
// - Counter state lasts from command receipt until busy bit clears.
// - Suspend ignored during counter state; counter command continues.
module flash_op_arbiter (
    input wire logic clk_sys_in, // System clock, 125 MHz
    input wire logic rst_in, // Synchronous reset, active high
    input wire logic link_clk_in, // Link clock
    input wire logic link_rst_in, // Link-domain reset, active high
    input wire logic txn_valid_in, // Transaction strobe, link domain
    input wire logic [3:0] txn_kind_in, // Transaction kind, link domain
    input wire logic pe_done_in, // Program/erase finished
    input wire logic ctr_done_in, // Counter unit finished
    input wire logic [7:0] ctr_status_in, // Counter unit completion status
    output logic grant_out, // Transaction honoured pulse
    output logic refuse_out, // Transaction refused pulse
    output logic ignore_out, // Transaction ignored pulse
    output flash_arb_pkg::kind_t kind_out, // Kind of last decided transaction
    output flash_arb_pkg::state_t state_out, // Operation state
    output logic [7:0] status_byte_out, // Ordinary status register
    output logic [7:0] ext_status_out, // Counter extended status
    output logic [7:0] fill_byte_out // Erased array byte value
);
    import flash_arb_pkg::*;

    localparam logic [11:0] SUSP_CYC = 12'(`SUSP_LAT_CYC);

    // Link domain: capture kind and flip toggle per transaction
    logic [3:0] lk_kind_q, lk_kind_d;
    logic lk_tog_q, lk_tog_d;

    always_comb begin
        lk_kind_d = lk_kind_q;
        lk_tog_d = lk_tog_q;
        if (txn_valid_in) begin
            lk_kind_d = txn_kind_in;
            lk_tog_d = ~lk_tog_q;
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (link_rst_in) begin
            lk_kind_q <= 4'h0;
            lk_tog_q <= 1'b0;
        end else begin
            lk_kind_q <= lk_kind_d;
            lk_tog_q <= lk_tog_d;
        end
    end

    // Event crossing; kind is stable long before the pulse arrives
    logic txn_ev;
    toggle_sync u_sync (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .tog_in(lk_tog_q),
        .pulse_out(txn_ev)
    );
    kind_t kind_w;
    assign kind_w = kind_t'(lk_kind_q);

    // System domain state
    state_t state_q, state_d;
    logic nosusp_q, nosusp_d;
    logic ctr_busy_q, ctr_busy_d;
    logic [11:0] cnt_q, cnt_d;
    logic [7:0] status_q, status_d;
    logic [7:0] ext_q, ext_d;
    logic [7:0] fill_q;
    logic grant_q, grant_d, refuse_q, refuse_d, ignore_q, ignore_d;
    kind_t kind_q, kind_d;
    logic is_write;

    assign is_write = (kind_w == K_PROGRAM) || (kind_w == K_ERASE_BLK) ||
                      (kind_w == K_ERASE_CHIP) || (kind_w == K_WRSR);

    // Next-state and decision logic
    always_comb begin
        state_d = state_q;
        nosusp_d = nosusp_q;
        ctr_busy_d = ctr_busy_q;
        cnt_d = cnt_q;
        ext_d = ext_q;
        grant_d = 1'b0;
        refuse_d = 1'b0;
        ignore_d = 1'b0;
        kind_d = kind_q;
        // Counter completion clears busy, loads result
        if (ctr_done_in && ctr_busy_q) begin
            ctr_busy_d = 1'b0;
            ext_d = {ctr_status_in[7:1], 1'b0};
            if (state_q == ST_CTR) begin
                state_d = ST_IDLE;
            end
        end
        case (state_q)
            ST_PE_RUN: begin
                if (pe_done_in) begin
                    // A counter command still busy keeps the counter state alive
                    if (ctr_busy_d) begin
                        state_d = ST_CTR;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_PE_SUSPENDING: begin
                cnt_d = cnt_q - 12'h001;
                if (cnt_q == 12'h001) begin
                    state_d = ST_PE_SUSP;
                end
            end
            default: begin
            end
        endcase
        if (txn_ev) begin
            kind_d = kind_w;
            case (state_q)
                ST_IDLE: begin
                    if ((kind_w == K_SUSPEND) || (kind_w == K_RESUME)) begin
                        ignore_d = 1'b1;
                    end else begin
                        grant_d = 1'b1;
                        if (is_write) begin
                            state_d = ST_PE_RUN;
                            nosusp_d = (kind_w == K_ERASE_CHIP) || (kind_w == K_WRSR);
                        end else if (kind_w == K_CTR_CMD) begin
                            state_d = ST_CTR;
                            ctr_busy_d = 1'b1;
                            ext_d = 8'h01;
                        end
                    end
                end
                ST_CTR: begin
                    if ((kind_w == K_SUSPEND) || (kind_w == K_RESUME)) begin
                        ignore_d = 1'b1;
                    end else if (kind_w == K_CTR_CMD) begin
                        refuse_d = 1'b1;
                    end else begin
                        grant_d = 1'b1;
                    end
                end
                ST_PE_RUN, ST_PE_SUSPENDING: begin
                    if ((kind_w == K_SUSPEND) && (state_q == ST_PE_RUN) && !nosusp_q) begin
                        grant_d = 1'b1;
                        state_d = ST_PE_SUSPENDING;
                        cnt_d = SUSP_CYC;
                    end else if ((kind_w == K_CTR_CMD) && !ctr_busy_q) begin
                        grant_d = 1'b1;
                        ctr_busy_d = 1'b1;
                        ext_d = 8'h01;
                    end else if ((kind_w == K_CTR_STATUS) || (kind_w == K_STATUS_READ)) begin
                        grant_d = 1'b1;
                    end else begin
                        refuse_d = 1'b1;
                    end
                end
                ST_PE_SUSP: begin
                    if (kind_w == K_RESUME) begin
                        grant_d = 1'b1;
                        state_d = ST_PE_RUN;
                    end else if ((kind_w == K_CTR_CMD) && !ctr_busy_q) begin
                        grant_d = 1'b1;
                        ctr_busy_d = 1'b1;
                        ext_d = 8'h01;
                    end else if ((kind_w == K_READ) || (kind_w == K_CTR_STATUS) ||
                                 (kind_w == K_STATUS_READ)) begin
                        grant_d = 1'b1;
                    end else begin
                        refuse_d = 1'b1;
                    end
                end
                default: begin
                    refuse_d = 1'b1;
                end
            endcase
        end
        // Status byte mirrors the resulting operation
        status_d = `STATUS_RESET;
        status_d[`ST_BUSY_BIT] = (state_d == ST_PE_RUN) || (state_d == ST_PE_SUSPENDING) ||
                                 ctr_busy_d;
        status_d[`ST_SUSDONE_BIT] = (state_d == ST_PE_SUSP);
    end

    // Register stage for the system domain
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            nosusp_q <= 1'b0;
            ctr_busy_q <= 1'b0;
            cnt_q <= 12'h000;
            status_q <= `STATUS_RESET;
            ext_q <= `EXT_RESET;
            fill_q <= `FILL_BYTE;
            grant_q <= 1'b0;
            refuse_q <= 1'b0;
            ignore_q <= 1'b0;
            kind_q <= K_SUSPEND;
        end else begin
            state_q <= state_d;
            nosusp_q <= nosusp_d;
            ctr_busy_q <= ctr_busy_d;
            cnt_q <= cnt_d;
            status_q <= status_d;
            ext_q <= ext_d;
            fill_q <= `FILL_BYTE;
            grant_q <= grant_d;
            refuse_q <= refuse_d;
            ignore_q <= ignore_d;
            kind_q <= kind_d;
        end
    end

    assign grant_out = grant_q;
    assign refuse_out = refuse_q;
    assign ignore_out = ignore_q;
    assign kind_out = kind_q;
    assign state_out = state_q;
    assign status_byte_out = status_q;
    assign ext_status_out = ext_q;
    assign fill_byte_out = fill_q;

    // Checks on the decision logic
    AST_SUSP_WITH_DONE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == ST_PE_SUSP) == status_q[`ST_SUSDONE_BIT])
        else $error("suspended state and suspend-done bit disagree");
    AST_CTR_IN_PE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        txn_ev && (kind_w == K_CTR_CMD) && (state_q == ST_PE_SUSP) && !ctr_busy_q
        |=> grant_out && ctr_busy_q && (state_q == ST_PE_SUSP))
        else $error("counter command not accepted while suspended");
    AST_SUSPEND_MOVES: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        txn_ev && (kind_w == K_SUSPEND) && (state_q == ST_PE_RUN) && !nosusp_q && !pe_done_in
        |=> (state_q == ST_PE_SUSPENDING) ##1 (state_q == ST_PE_SUSPENDING) && (cnt_q == SUSP_CYC - 12'h001))
        else $error("suspend did not start suspension");
    AST_SUSPEND_REFUSED: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        txn_ev && (kind_w == K_SUSPEND) && (state_q == ST_PE_RUN) && nosusp_q && !pe_done_in
        |=> refuse_out && (state_q == ST_PE_RUN))
        else $error("suspend of chip erase or status write not refused");
    AST_EXT_BUSY: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ctr_busy_q |-> ext_q[`EXT_BUSY_BIT] && status_q[`ST_BUSY_BIT])
        else $error("counter busy not shown in extended status");
    AST_EXT_HELD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == ST_PE_RUN) && !ctr_busy_q && !txn_ev |=> $stable(ext_status_out))
        else $error("counter status changed during program/erase");
    AST_WRITE_BUSY: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        txn_ev && (state_q == ST_IDLE) && is_write |=> grant_out && status_q[`ST_BUSY_BIT])
        else $error("accepted write not shown busy");
    AST_RESET_VALUES: assert property (@(posedge clk_sys_in)
        $past(rst_in) |-> (status_q == 8'h00) && (fill_q == 8'hFF))
        else $error("status or fill byte wrong after reset");
    AST_CTR_ENDS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == ST_CTR) && ctr_done_in |=> (state_q == ST_IDLE) && !ext_q[`EXT_BUSY_BIT])
        else $error("counter state did not end with busy clear");
    AST_CTR_IGNORES_SUSPEND: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        txn_ev && (kind_w == K_SUSPEND) && (state_q == ST_CTR) && !ctr_done_in
        |=> ignore_out && (state_q == ST_CTR))
        else $error("suspend not ignored in counter state");
    AST_PE_REFUSES_READ: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        txn_ev && (kind_w == K_READ) && (state_q == ST_PE_RUN) |=> refuse_out)
        else $error("read not refused during program/erase");
    AST_RESUME_RETURNS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        txn_ev && (kind_w == K_RESUME) && (state_q == ST_PE_SUSP) |=> grant_out && (state_q == ST_PE_RUN))
        else $error("resume did not return to program/erase");
    AST_SUSP_ONLY_AFTER_WAIT: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(state_q == ST_PE_SUSP) |-> ($past(state_q) == ST_PE_SUSPENDING) && ($past(cnt_q) == 12'h001))
        else $error("suspended state entered without finished suspend wait");
    AST_STATUS_READ_SERVED: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        txn_ev && (kind_w == K_STATUS_READ) |=> grant_out)
        else $error("status read not served");
    AST_SUSP_REFUSES_WRITE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        txn_ev && is_write && (state_q == ST_PE_SUSP) |=> refuse_out && (state_q == ST_PE_SUSP))
        else $error("write or erase not refused while suspended");
    AST_SUSP_READ_GRANTED: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        txn_ev && (kind_w == K_READ) && (state_q == ST_PE_SUSP) |=> grant_out && (state_q == ST_PE_SUSP))
        else $error("array read not served while suspended");
    AST_CTR_GRANTS_WRITE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        txn_ev && is_write && (state_q == ST_CTR) && !ctr_done_in
        |=> grant_out && (state_q == ST_CTR))
        else $error("write not allowed in counter state");
    AST_READOUT_SERVED: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        txn_ev && (kind_w == K_CTR_STATUS) && ((state_q == ST_PE_RUN) || (state_q == ST_PE_SUSP)) && !ctr_done_in
        |=> grant_out && $stable(ext_q))
        else $error("counter readout not served with last status");
    AST_DONE_CLEARS_BUSY: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ctr_busy_q && ctr_done_in && !txn_ev
        |=> !ctr_busy_q && !ext_q[`EXT_BUSY_BIT] && (ext_q[7:1] == $past(ctr_status_in[7:1])))
        else $error("counter completion did not post its result");
    AST_PE_DONE_WITH_CTR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == ST_PE_RUN) && pe_done_in && ctr_busy_q && !ctr_done_in && !txn_ev |=> (state_q == ST_CTR))
        else $error("busy counter command lost its state at program/erase end");
endmodule : flash_op_arbiter

// ### tb/host_ctrl_model.sv
// Host-side flash controller model: link clock and transaction strobes
`timescale 1ns/1ps
module host_ctrl_model (
    output logic link_clk_out, // Link clock, runs only during link reset and within a frame
    output logic link_rst_out, // Link-domain reset, active high
    output logic txn_valid_out, // One-cycle transaction strobe
    output logic [3:0] txn_kind_out // Transaction kind
);
    // Idle levels at time zero
    initial begin
        link_clk_out = 1'b0;
        link_rst_out = 1'b1;
        txn_valid_out = 1'b0;
        txn_kind_out = 4'h0;
    end
    // Two link pulses under reset, then release; clock stops afterwards
    task automatic reset_link();
        link_rst_out = 1'b1;
        repeat (2) begin
            #32 link_clk_out = 1'b1;
            #32 link_clk_out = 1'b0;
        end
        link_rst_out = 1'b0;
    endtask : reset_link
    // One frame: strobe taken at the first rising edge, kind line scrambled once released
    task automatic send(input logic [3:0] kind);
        #5 txn_valid_out = 1'b1;
        txn_kind_out = kind;
        #28 link_clk_out = 1'b1;
        #32 link_clk_out = 1'b0;
        txn_valid_out = 1'b0;
        txn_kind_out = ~kind;
        #32 link_clk_out = 1'b1;
        #32 link_clk_out = 1'b0;
    endtask : send
endmodule : host_ctrl_model

// ### tb/tb_flash_op_arbiter.sv
// Self-checking bench for the flash operation-state arbiter
`timescale 1ns/1ps
`include "flash_arb_cfg.svh"
module tb_flash_op_arbiter;
    import flash_arb_pkg::*;
    localparam logic [2:0] GNT = 3'b100;
    localparam logic [2:0] REF = 3'b010;
    localparam logic [2:0] IGN = 3'b001;
    logic clk_sys_in, rst_in, link_clk, link_rst, txn_valid, pe_done_in, ctr_done_in;
    logic [3:0] txn_kind;
    logic [7:0] ctr_status_in, status_o, ext_o, fill_o, last_ext;
    logic grant, refuse, ignore;
    kind_t kind_o;
    state_t state_o;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    host_ctrl_model i_host_ctrl_model (.link_clk_out(link_clk), .link_rst_out(link_rst),
        .txn_valid_out(txn_valid), .txn_kind_out(txn_kind));
    flash_op_arbiter i_flash_op_arbiter (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link_clk_in(link_clk),
        .link_rst_in(link_rst), .txn_valid_in(txn_valid), .txn_kind_in(txn_kind), .pe_done_in(pe_done_in),
        .ctr_done_in(ctr_done_in), .ctr_status_in(ctr_status_in), .grant_out(grant), .refuse_out(refuse),
        .ignore_out(ignore), .kind_out(kind_o), .state_out(state_o), .status_byte_out(status_o),
        .ext_status_out(ext_o), .fill_byte_out(fill_o));
    // System clock
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    // Verdict and end of run
    task automatic test_done();
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    // Hang guard, well above the expected run length
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            $display("ERROR at %0t: timeout", $time);
            test_done();
        end
    end
    // One comparison
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            failures++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask : chk
    // Send one transaction and judge the decision pulse, kind and state
    task automatic do_txn(input kind_t k, input logic [2:0] exp, input state_t st);
        logic [2:0] seen;
        seen = 3'b000;
        fork
            i_host_ctrl_model.send(k);
            for (int i = 0; i < 30 && seen === 3'b000; i++) begin
                @(negedge clk_sys_in);
                seen = {grant, refuse, ignore};
            end
        join
        @(negedge clk_sys_in);
        chk(seen === exp && kind_o === k && state_o === st, $sformatf("decision on kind %0d", k));
    endtask : do_txn
    // Counter unit completion; bit 0 of the result reads back clear
    task automatic ctr_finish(input logic [7:0] s);
        ctr_status_in = s;
        ctr_done_in = 1'b1;
        @(negedge clk_sys_in);
        ctr_done_in = 1'b0;
        @(negedge clk_sys_in);
        last_ext = s & 8'hFE;
        chk(ext_o === last_ext, "counter result");
    endtask : ctr_finish
    // Program/erase completion; a busy counter command keeps the counter state
    task automatic pe_finish(input state_t st);
        pe_done_in = 1'b1;
        @(negedge clk_sys_in);
        pe_done_in = 1'b0;
        @(negedge clk_sys_in);
        chk(state_o === st && status_o === ((st == ST_IDLE) ? 8'h00 : 8'h01), "program/erase end");
    endtask : pe_finish
    // Values after reset
    task automatic t_reset();
        chk(state_o === ST_IDLE && status_o === `STATUS_RESET && ext_o === 8'h00, "reset status");
        chk(fill_o === `FILL_BYTE, "fill byte");
    endtask : t_reset
    // Counter command state: what is ignored, granted and refused
    task automatic t_counter();
        kind_t wr[5] = '{K_READ, K_PROGRAM, K_ERASE_BLK, K_ERASE_CHIP, K_WRSR};
        do_txn(K_CTR_CMD, GNT, ST_CTR);
        chk(ext_o === 8'h01 && status_o[`ST_BUSY_BIT] === 1'b1, "counter busy");
        do_txn(K_SUSPEND, IGN, ST_CTR);
        do_txn(K_RESUME, IGN, ST_CTR);
        foreach (wr[i]) do_txn(wr[i], GNT, ST_CTR);
        do_txn(K_CTR_CMD, REF, ST_CTR);
        do_txn(K_CTR_STATUS, GNT, ST_CTR);
        chk(ext_o === 8'h01, "readout busy");
        ctr_finish(8'h81);
        do_txn(K_STATUS_READ, GNT, ST_IDLE);
        chk(status_o === 8'h00, "idle status");
    endtask : t_counter
    // Program/erase run, optional suspend and resume
    task automatic t_pe(input kind_t k, input logic susp_ok);
        int n;
        do_txn(k, GNT, ST_PE_RUN);
        chk(status_o[`ST_BUSY_BIT] === 1'b1, "busy in program/erase");
        do_txn(K_READ, REF, ST_PE_RUN);
        do_txn(K_PROGRAM, REF, ST_PE_RUN);
        do_txn(K_WRSR, REF, ST_PE_RUN);
        do_txn(K_CTR_STATUS, GNT, ST_PE_RUN);
        chk(ext_o === last_ext, "readout in program/erase");
        do_txn(K_CTR_CMD, GNT, ST_PE_RUN);
        ctr_finish({k, 4'h5});
        if (!susp_ok) begin
            do_txn(K_SUSPEND, REF, ST_PE_RUN);
            do_txn(K_CTR_CMD, GNT, ST_PE_RUN);
            pe_finish(ST_CTR);
            ctr_finish({k, 4'h9});
            chk(state_o === ST_IDLE && status_o === 8'h00, "counter end after program/erase");
            return;
        end
        do_txn(K_SUSPEND, GNT, ST_PE_SUSPENDING);
        for (n = 0; n < `SUSP_LAT_CYC + 20 && state_o !== ST_PE_SUSP; n++) begin
            @(negedge clk_sys_in);
            chk(status_o[`ST_SUSDONE_BIT] === (state_o === ST_PE_SUSP), "suspend flag");
        end
        chk(state_o === ST_PE_SUSP && n > `SUSP_LAT_CYC - 20, "suspend latency");
        do_txn(K_READ, GNT, ST_PE_SUSP);
        do_txn(K_ERASE_BLK, REF, ST_PE_SUSP);
        do_txn(K_WRSR, REF, ST_PE_SUSP);
        do_txn(K_SUSPEND, REF, ST_PE_SUSP);
        do_txn(K_CTR_CMD, GNT, ST_PE_SUSP);
        ctr_finish({k, 4'hA});
        do_txn(K_CTR_STATUS, GNT, ST_PE_SUSP);
        chk(ext_o === last_ext, "readout when suspended");
        do_txn(K_RESUME, GNT, ST_PE_RUN);
        pe_finish(ST_IDLE);
    endtask : t_pe
    // Main sequence
    initial begin
        rst_in = 1'b1;
        pe_done_in = 1'b0;
        ctr_done_in = 1'b0;
        ctr_status_in = 8'h00;
        last_ext = 8'h00;
        fork
            i_host_ctrl_model.reset_link();
            begin
                repeat (4) @(negedge clk_sys_in);
                rst_in = 1'b0;
            end
        join
        repeat (4) @(negedge clk_sys_in);
        t_reset();
        t_counter();
        t_pe(K_PROGRAM, 1'b1);
        t_pe(K_ERASE_BLK, 1'b1);
        t_pe(K_ERASE_CHIP, 1'b0);
        t_pe(K_WRSR, 1'b0);
        test_done();
    end
endmodule : tb_flash_op_arbiter
